/* File: verilog/t16_pkg.sv */
// Constants shared by the 16-bit timer with capture and compare
package t16_pkg;
	// Register byte addresses on the APB bus, one aligned word each
	localparam logic [7:0] OFF_CTRL_A = 8'h00;
	localparam logic [7:0] OFF_CTRL_B = 8'h04;
	localparam logic [7:0] OFF_FORCE = 8'h08;
	localparam logic [7:0] OFF_CNT_L = 8'h0C;
	localparam logic [7:0] OFF_CNT_H = 8'h10;
	localparam logic [7:0] OFF_OCRA_L = 8'h14;
	localparam logic [7:0] OFF_OCRA_H = 8'h18;
	localparam logic [7:0] OFF_OCRB_L = 8'h1C;
	localparam logic [7:0] OFF_OCRB_H = 8'h20;
	localparam logic [7:0] OFF_ICR_L = 8'h24;
	localparam logic [7:0] OFF_ICR_H = 8'h28;
	localparam logic [7:0] OFF_MASK = 8'h2C;
	localparam logic [7:0] OFF_FLAGS = 8'h30;
	// Reset values and writable-bit masks
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] CTRL_A_RW_MASK = 8'hF3;
	localparam logic [7:0] CTRL_B_RW_MASK = 8'hDF;
	localparam logic [7:0] IRQ_BITS_MASK = 8'hE8;
	// Field positions
	localparam int CB_FILT = 7;
	localparam int CB_EDGE = 6;
	localparam int CB_WGM_HI = 3;
	localparam int CB_CS = 0;
	localparam int CA_COM_A = 6;
	localparam int CA_COM_B = 4;
	localparam int FRC_A = 7;
	localparam int FRC_B = 6;
	localparam int FL_OVF = 7;
	localparam int FL_MA = 6;
	localparam int FL_MB = 5;
	localparam int FL_CAP = 3;
	// Counter, prescaler and filter sizes
	localparam int PRE_W = 10;
	localparam int FILT_SAMPLES = 4;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8B = 16'h00FF;
	localparam logic [15:0] TOP_9B = 16'h01FF;
	localparam logic [15:0] TOP_10B = 16'h03FF;
	typedef enum logic [2:0] {
		CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
		CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
	} t16_cs_type;
	typedef enum logic [1:0] {
		KIND_NON = 2'b00, KIND_FAST = 2'b01, KIND_PC = 2'b10
	} t16_kind_type;
endpackage

/* File: verilog/t16_timer.sv */
// 16-bit timer/counter with input capture, two compare channels and APB registers
// Function
// - With filter on, filtered capture input changes only after four equal samples.
// - Edge select bit: zero triggers capture on falling edge, one on rising.
// - Capture copies the counter into the capture register and sets capture flag.
// - Modes using capture register as top disable the capture input.
// - Clock select: stop, /1, /8, /64, /256, /1024, external fall, rise.
// - External pin edges advance the counter regardless of pin direction.
// - Force strobes act only in non-PWM modes, ignored in PWM modes.
// - A force strobe applies an immediate match to the channel output.
// - A force strobe sets no flag, raises no interrupt, never clears the counter.
// - Force strobe bits always read as zero.
// - Counter is accessed atomically through one shared temporary high byte.
// - A counter write suppresses compare matches on the next timer clock.
// - Both compare registers are compared continuously with the counter.
// - Compare registers are written atomically through the temporary high byte.
// - Capture loads the counter on pin events or selected comparator events.
// - Capture register reads are atomic through the temporary high byte.
// - Overflow interrupt needs its enable, the global enable and its flag.
// - Match A interrupt needs its enable, the global enable and its flag.
// - Match B interrupt needs its enable, the global enable and its flag.
// - Capture interrupt needs its enable, the global enable and its flag.
// - Four waveform mode bits across both control registers pick sixteen modes.
// - Match flags set in the timer clock after counter equals compare value.
// - Flags clear on vector acknowledge or by writing one to them.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
module t16_timer
	import t16_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_input_pin,
	input wire logic external_count_pin,
	input wire logic comparator_out,
	input wire logic comparator_capture_sel,
	input wire logic global_irq_en,
	input wire logic [3:0] vector_ack,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic irq_overflow,
	output logic irq_match_a,
	output logic irq_match_b,
	output logic irq_capture
);
	logic [7:0] ctrl_a_ff, ctrl_b_ff, mask_ff, flags_ff, temp_ff, pend_hi_ff, rd_byte;
	logic [15:0] cnt_ff, ocra_ff, ocrb_ff, icr_ff, top;
	logic [2:0] s1_ff, s2_ff, s3_ff, clean_ff, eq;
	logic [FILT_SAMPLES-1:0] hist_ff;
	logic [PRE_W-1:0] pre_ff;
	logic [31:0] prdata_ff;
	logic [3:0] irq_ff;
	logic [3:0] mode;
	logic pready_ff, pslverr_ff, filt_ff, filt_prev_ff, ext_prev_ff, up_ff, block_ff;
	logic wave_a_ff, wave_b_ff, setup, acc, wr, rd, cap_src, cap_edge, cap_evt, icr_top;
	logic tick, at_top, match_a, match_b, set_ovf, set_cap, frc_a, frc_b, cnt_wr;
	logic [7:0] flag_set, flag_clr;
	t16_kind_type kind;

	function automatic t16_kind_type kind_of(input logic [3:0] m);
		case (m)
			4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11: return KIND_PC;
			4'd5, 4'd6, 4'd7, 4'd14, 4'd15: return KIND_FAST;
			default: return KIND_NON;
		endcase
	endfunction

	// Next level of one waveform output after a match, a top event or a force
	function automatic logic wave_next(input logic o, input logic [1:0] com,
		input t16_kind_type k, input logic up, input logic m, input logic at_t,
		input logic frc, input logic tog);
		logic r;
		r = o;
		if (k == KIND_NON)
		begin
			if (m || frc)
				r = (com == 2'b01) ? ~o : ((com == 2'b00) ? o : com[0]);
		end
		else if (com == 2'b01)
		begin
			if (tog && m)
				r = ~o;
		end
		else if (com[1])
		begin
			if (k == KIND_FAST)
			begin
				if (m)
					r = com[0];
				// A match at top is overridden by the top action
				if (at_t)
					r = ~com[0];
			end
			else if (m)
				r = up ? com[0] : ~com[0];
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			OFF_CTRL_A, OFF_CTRL_B, OFF_FORCE, OFF_CNT_L, OFF_CNT_H, OFF_OCRA_L,
			OFF_OCRA_H, OFF_OCRB_L, OFF_OCRB_H, OFF_ICR_L, OFF_ICR_H, OFF_MASK,
			OFF_FLAGS: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign wave_out_a = wave_a_ff;
	assign wave_out_b = wave_b_ff;
	assign irq_overflow = irq_ff[3];
	assign irq_match_a = irq_ff[2];
	assign irq_match_b = irq_ff[1];
	assign irq_capture = irq_ff[0];

	assign setup = psel && !penable;
	assign acc = psel && penable && pready_ff;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign mode = {ctrl_b_ff[CB_WGM_HI +: 2], ctrl_a_ff[1:0]};
	assign kind = kind_of(mode);
	assign icr_top = (mode == 4'd8) || (mode == 4'd10) || (mode == 4'd12) || (mode == 4'd14);
	assign cnt_wr = wr && (paddr == OFF_CNT_L);

	always_comb
	begin
		case (mode)
			4'd1, 4'd5: top = TOP_8B;
			4'd2, 4'd6: top = TOP_9B;
			4'd3, 4'd7: top = TOP_10B;
			4'd4, 4'd9, 4'd11, 4'd15: top = ocra_ff;
			4'd8, 4'd10, 4'd12, 4'd14: top = icr_ff;
			default: top = TOP_MAX;
		endcase
	end

	// APB slave: one wait-free access phase, answer registered at setup
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pend_hi_ff <= RST_BYTE;
		end
		else
		begin
			pready_ff <= setup;
			pslverr_ff <= setup && !mapped(paddr);
			if (setup)
			begin
				prdata_ff <= {24'h00_0000, rd_byte};
				pend_hi_ff <= (paddr == OFF_ICR_L) ? icr_ff[15:8] : cnt_ff[15:8];
			end
		end
	end

	always_comb
	begin
		case (paddr)
			OFF_CTRL_A: rd_byte = ctrl_a_ff;
			OFF_CTRL_B: rd_byte = ctrl_b_ff;
			OFF_FORCE: rd_byte = RST_BYTE;
			OFF_CNT_L: rd_byte = cnt_ff[7:0];
			OFF_CNT_H, OFF_ICR_H: rd_byte = temp_ff;
			OFF_OCRA_L: rd_byte = ocra_ff[7:0];
			OFF_OCRA_H: rd_byte = ocra_ff[15:8];
			OFF_OCRB_L: rd_byte = ocrb_ff[7:0];
			OFF_OCRB_H: rd_byte = ocrb_ff[15:8];
			OFF_ICR_L: rd_byte = icr_ff[7:0];
			OFF_MASK: rd_byte = mask_ff;
			OFF_FLAGS: rd_byte = flags_ff;
			default: rd_byte = RST_BYTE;
		endcase
	end

	// Shared temporary high byte
	always_ff @(posedge clk)
	begin
		if (srst)
			temp_ff <= RST_BYTE;
		else if (wr && (paddr == OFF_CNT_H || paddr == OFF_OCRA_H ||
			paddr == OFF_OCRB_H || paddr == OFF_ICR_H))
			temp_ff <= pwdata[7:0];
		else if (rd && (paddr == OFF_CNT_L || paddr == OFF_ICR_L))
			temp_ff <= pend_hi_ff;
	end

	// Control and mask registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_a_ff <= RST_BYTE;
			ctrl_b_ff <= RST_BYTE;
			mask_ff <= RST_BYTE;
		end
		else if (wr)
		begin
			if (paddr == OFF_CTRL_A)
				ctrl_a_ff <= pwdata[7:0] & CTRL_A_RW_MASK;
			if (paddr == OFF_CTRL_B)
				ctrl_b_ff <= pwdata[7:0] & CTRL_B_RW_MASK;
			if (paddr == OFF_MASK)
				mask_ff <= pwdata[7:0] & IRQ_BITS_MASK;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ocra_ff <= RST_WORD;
			ocrb_ff <= RST_WORD;
		end
		else if (wr)
		begin
			if (paddr == OFF_OCRA_L)
				ocra_ff <= {temp_ff, pwdata[7:0]};
			if (paddr == OFF_OCRB_L)
				ocrb_ff <= {temp_ff, pwdata[7:0]};
		end
	end

	// Pin synchronisers: a change counts once stages two and three agree
	assign eq = ~(s2_ff ^ s3_ff);
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s1_ff <= 3'h0;
			s2_ff <= 3'h0;
			s3_ff <= 3'h0;
			clean_ff <= 3'h0;
		end
		else
		begin
			s1_ff <= {comparator_out, capture_input_pin, external_count_pin};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			clean_ff <= (s3_ff & eq) | (clean_ff & ~eq);
		end
	end

	// Capture source, noise filter and edge detection
	assign cap_src = comparator_capture_sel ? clean_ff[2] : clean_ff[1];
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			hist_ff <= '0;
			filt_ff <= 1'b0;
			filt_prev_ff <= 1'b0;
		end
		else
		begin
			hist_ff <= {hist_ff[FILT_SAMPLES-2:0], cap_src};
			filt_prev_ff <= filt_ff;
			if (!ctrl_b_ff[CB_FILT])
				filt_ff <= cap_src;
			else if (&hist_ff)
				filt_ff <= 1'b1;
			else if (~|hist_ff)
				filt_ff <= 1'b0;
		end
	end
	assign cap_edge = ctrl_b_ff[CB_EDGE] ? (filt_ff && !filt_prev_ff)
		: (!filt_ff && filt_prev_ff);
	assign cap_evt = cap_edge && !icr_top;

	// Prescaler runs free; external pin edges are seen through the synchroniser
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pre_ff <= '0;
			ext_prev_ff <= 1'b0;
		end
		else
		begin
			pre_ff <= pre_ff + 1'b1;
			ext_prev_ff <= clean_ff[0];
		end
	end

	always_comb
	begin
		case (t16_cs_type'(ctrl_b_ff[CB_CS +: 3]))
			CS_STOP: tick = 1'b0;
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = &pre_ff[2:0];
			CS_DIV64: tick = &pre_ff[5:0];
			CS_DIV256: tick = &pre_ff[7:0];
			CS_DIV1024: tick = &pre_ff[9:0];
			CS_EXT_FALL: tick = ext_prev_ff && !clean_ff[0];
			CS_EXT_RISE: tick = !ext_prev_ff && clean_ff[0];
			default: tick = 1'b0;
		endcase
	end

	assign at_top = (cnt_ff == top);
	assign match_a = tick && !block_ff && (cnt_ff == ocra_ff);
	assign match_b = tick && !block_ff && (cnt_ff == ocrb_ff);
	assign set_ovf = tick && ((kind == KIND_PC) ? (cnt_ff == RST_WORD && !up_ff)
		: ((kind == KIND_FAST) ? at_top : (cnt_ff == TOP_MAX)));
	assign set_cap = cap_evt || (tick && icr_top && at_top);
	assign frc_a = wr && paddr == OFF_FORCE && pwdata[FRC_A] && kind == KIND_NON;
	assign frc_b = wr && paddr == OFF_FORCE && pwdata[FRC_B] && kind == KIND_NON;

	// Counter; a bus write wins over a timer clock in the same cycle
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt_ff <= RST_WORD;
			up_ff <= 1'b1;
			block_ff <= 1'b0;
		end
		else
		begin
			if (cnt_wr)
				block_ff <= 1'b1;
			else if (tick)
				block_ff <= 1'b0;
			if (cnt_wr)
				cnt_ff <= {temp_ff, pwdata[7:0]};
			else if (tick && kind == KIND_PC)
			begin
				if (up_ff && at_top)
				begin
					up_ff <= 1'b0;
					cnt_ff <= cnt_ff - 1'b1;
				end
				else if (!up_ff && cnt_ff == RST_WORD)
				begin
					up_ff <= 1'b1;
					cnt_ff <= cnt_ff + 1'b1;
				end
				else
					cnt_ff <= up_ff ? cnt_ff + 1'b1 : cnt_ff - 1'b1;
			end
			else if (tick)
			begin
				up_ff <= 1'b1;
				cnt_ff <= at_top ? RST_WORD : cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			icr_ff <= RST_WORD;
		else if (wr && paddr == OFF_ICR_L)
			icr_ff <= {temp_ff, pwdata[7:0]};
		else if (cap_evt)
			icr_ff <= cnt_ff;
	end

	// Flags: a hardware set wins over a clear in the same cycle
	assign flag_set = {set_ovf, match_a, match_b, 1'b0, set_cap, 3'b000};
	assign flag_clr = ((wr && paddr == OFF_FLAGS) ? pwdata[7:0] : RST_BYTE)
		| {vector_ack[3:1], 1'b0, vector_ack[0], 3'b000};
	always_ff @(posedge clk)
	begin
		if (srst)
			flags_ff <= RST_BYTE;
		else
			flags_ff <= ((flags_ff & ~flag_clr) | flag_set) & IRQ_BITS_MASK;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			irq_ff <= 4'h0;
		else
		begin
			irq_ff[3] <= global_irq_en && mask_ff[FL_OVF] && flags_ff[FL_OVF];
			irq_ff[2] <= global_irq_en && mask_ff[FL_MA] && flags_ff[FL_MA];
			irq_ff[1] <= global_irq_en && mask_ff[FL_MB] && flags_ff[FL_MB];
			irq_ff[0] <= global_irq_en && mask_ff[FL_CAP] && flags_ff[FL_CAP];
		end
	end

	// Waveform outputs
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wave_a_ff <= 1'b0;
			wave_b_ff <= 1'b0;
		end
		else
		begin
			wave_a_ff <= wave_next(wave_a_ff, ctrl_a_ff[CA_COM_A +: 2], kind, up_ff,
				match_a, tick && at_top, frc_a, mode[3]);
			wave_b_ff <= wave_next(wave_b_ff, ctrl_a_ff[CA_COM_B +: 2], kind, up_ff,
				match_b, tick && at_top, frc_b, 1'b0);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	filter_hold_a: assert property (($past(ctrl_b_ff[CB_FILT]) && ctrl_b_ff[CB_FILT] &&
		filt_ff != $past(filt_ff)) |-> $past(hist_ff) == {FILT_SAMPLES{filt_ff}})
		else $error("filtered capture changed without four equal samples");
	capture_copy_a: assert property ((cap_evt && !(wr && paddr == OFF_ICR_L)) |=>
		(icr_ff == $past(cnt_ff)) && flags_ff[FL_CAP])
		else $error("capture did not load counter and set flag");
	capture_off_a: assert property ((icr_top && !(wr && paddr == OFF_ICR_L)) |=>
		$stable(icr_ff))
		else $error("capture register loaded while it is top");
	force_no_flag_a: assert property ((wr && paddr == OFF_FORCE && !tick) |=>
		!$rose(flags_ff[FL_MA]) && !$rose(flags_ff[FL_MB]))
		else $error("force strobe set a match flag");
	force_read_a: assert property ((setup && paddr == OFF_FORCE) |=>
		prdata_ff == 32'h0000_0000)
		else $error("force register read nonzero");
	// The first tick after a counter write must not raise a match flag
	count_block_a: assert property ((tick && block_ff && !cnt_wr) |=>
		!$rose(flags_ff[FL_MA]) && !$rose(flags_ff[FL_MB]))
		else $error("compare match not blocked after counter write");
	match_flag_a: assert property ((tick && !block_ff && cnt_ff == ocra_ff) |=>
		flags_ff[FL_MA])
		else $error("match A flag not set after equal count");
	ovf_irq_a: assert property (irq_overflow |-> $past(global_irq_en) &&
		$past(mask_ff[FL_OVF]) && $past(flags_ff[FL_OVF]))
		else $error("overflow interrupt without its causes");
	flag_clear_a: assert property ((wr && paddr == OFF_FLAGS && pwdata[FL_CAP] && !set_cap)
		|=> !flags_ff[FL_CAP])
		else $error("capture flag not cleared by writing one");
	// Reset is the antecedent here, so the default disable must not apply
	reset_ctrl_a: assert property (@(posedge clk) disable iff (1'b0) srst |=>
		ctrl_b_ff == RST_BYTE && mask_ff == RST_BYTE && !tick)
		else $error("control not cleared by reset");

	capture_seen_c: cover property (cap_evt ##1 flags_ff[FL_CAP]);
	force_seen_c: cover property (frc_a ##1 wave_a_ff != $past(wave_a_ff));
	irq_seen_c: cover property ($rose(irq_match_b));
endmodule

/* File: verification/timer16_capture_compare_ctrl_bench.sv */
// Self-checking bench for the 16-bit timer: APB registers, counting, compare, force and capture
`timescale 1ns/1ps
module timer16_capture_compare_ctrl_bench;
	import t16_pkg::*;
	logic clk;
	logic srst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic capture_input_pin;
	logic external_count_pin;
	logic comparator_out;
	logic comparator_capture_sel;
	logic global_irq_en;
	logic [3:0] vector_ack;
	logic wave_out_a;
	logic wave_out_b;
	logic irq_overflow;
	logic irq_match_a;
	logic irq_match_b;
	logic irq_capture;
	int n_errors;
	int compares;
	logic [31:0] rdat;
	logic rerr;
	t16_cs_type cs_tab [6] = '{CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
	int div_tab [6] = '{1, 1, 8, 64, 256, 1024};
	logic [7:0] rst_tab [7] = '{OFF_CTRL_A, OFF_CTRL_B, OFF_MASK, OFF_FLAGS, OFF_CNT_L,
		OFF_OCRA_H, OFF_ICR_L};

	t16_timer DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_pin(capture_input_pin), .external_count_pin(external_count_pin),
		.comparator_out(comparator_out), .comparator_capture_sel(comparator_capture_sel),
		.global_irq_en(global_irq_en), .vector_ack(vector_ack), .wave_out_a(wave_out_a),
		.wave_out_b(wave_out_b), .irq_overflow(irq_overflow), .irq_match_a(irq_match_a),
		.irq_match_b(irq_match_b), .irq_capture(irq_capture));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic test_done();
		$display("compares %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Entered just after a rising edge; leaves one idle cycle so strobes never clash
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1)
		begin
			n_errors++;
			test_done();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rdat, {24'h00_0000, exp});
	endtask

	// Counter is stopped during capture tests, so every capture holds the same value
	task automatic cap_try(input logic [7:0] cb, input logic pin, input logic cmp,
		input logic sel, input logic hit);
		wr(OFF_CTRL_B, cb);
		capture_input_pin <= pin;
		comparator_out <= cmp;
		comparator_capture_sel <= sel;
		wait_clk(16);
		rd_chk(OFF_FLAGS, hit ? 8'h08 : 8'h00);
		chk({31'h0000_0000, irq_capture}, {31'h0000_0000, hit});
		wr(OFF_FLAGS, 8'h08);
	endtask

	initial
	begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		capture_input_pin = 1'b0;
		external_count_pin = 1'b0;
		comparator_out = 1'b0;
		comparator_capture_sel = 1'b0;
		global_irq_en = 1'b0;
		vector_ack = 4'h0;
		n_errors = 0;
		compares = 0;
		wait_clk(2);
		srst <= 1'b0;
		wait_clk(2);
		foreach (rst_tab[i])
			rd_chk(rst_tab[i], RST_BYTE);
		chk({30'h0000_0000, wave_out_a, irq_overflow}, 32'h0000_0000);
		$display("test reset values done");

		wr(OFF_CTRL_B, 8'hE0);
		rd_chk(OFF_CTRL_B, 8'hC0);
		wr(OFF_CTRL_B, 8'h00);
		wr(OFF_CTRL_A, 8'hFF);
		rd_chk(OFF_CTRL_A, CTRL_A_RW_MASK);
		wr(OFF_CTRL_A, 8'h00);
		wr(OFF_MASK, 8'hFF);
		rd_chk(OFF_MASK, IRQ_BITS_MASK);
		apb(1'b0, 8'h34, 8'h00);
		chk({rerr, rdat[30:0]}, 32'h8000_0000);
		apb(1'b1, 8'h3C, 8'hFF);
		chk({31'h0000_0000, rerr}, 32'h0000_0001);
		wr(OFF_FORCE, 8'hC0);
		rd_chk(OFF_FORCE, 8'h00);
		wr(OFF_OCRA_H, 8'h12);
		wr(OFF_OCRA_L, 8'h34);
		wr(OFF_CNT_H, 8'hAB);
		wr(OFF_CNT_L, 8'hCD);
		rd_chk(OFF_OCRA_L, 8'h34);
		rd_chk(OFF_OCRA_H, 8'h12);
		rd_chk(OFF_CNT_L, 8'hCD);
		rd_chk(OFF_CNT_H, 8'hAB);
		// Temp is shared: a high byte staged for the counter lands in compare B
		wr(OFF_CNT_H, 8'h5A);
		wr(OFF_OCRB_L, 8'h01);
		rd_chk(OFF_OCRB_H, 8'h5A);
		$display("test register access done");

		// Window of 4*N active edges holds exactly four ticks unless stopped, whatever the prescaler phase
		foreach (cs_tab[i])
		begin
			wr(OFF_CNT_H, 8'h00);
			wr(OFF_CNT_L, 8'h00);
			wr(OFF_CTRL_B, {5'b0_0000, cs_tab[i]});
			wait_clk(4 * div_tab[i] - 3);
			wr(OFF_CTRL_B, 8'h00);
			rd_chk(OFF_CNT_L, (i == 0) ? 8'h00 : 8'h04);
		end
		for (int e = 0; e < 2; e++)
		begin
			wr(OFF_CNT_H, 8'h00);
			wr(OFF_CNT_L, 8'h00);
			wr(OFF_CTRL_B, (e == 0) ? 8'h06 : 8'h07);
			repeat (3)
			begin
				external_count_pin <= 1'b1;
				wait_clk(6);
				external_count_pin <= 1'b0;
				wait_clk(6);
			end
			wait_clk(8);
			wr(OFF_CTRL_B, 8'h00);
			rd_chk(OFF_CNT_L, 8'h03);
		end
		$display("test clock select done");

		global_irq_en <= 1'b1;
		wr(OFF_OCRA_H, 8'h00);
		wr(OFF_OCRA_L, 8'h10);
		wr(OFF_OCRB_H, 8'h00);
		wr(OFF_OCRB_L, 8'h00);
		wr(OFF_CNT_H, 8'h00);
		wr(OFF_CNT_L, 8'h00);
		wr(OFF_FLAGS, 8'hFF);
		wr(OFF_CTRL_B, 8'h01);
		wait_clk(30);
		wr(OFF_CTRL_B, 8'h00);
		rd_chk(OFF_FLAGS, 8'h40);
		chk({30'h0000_0000, irq_match_a, irq_match_b}, 32'h0000_0002);
		global_irq_en <= 1'b0;
		wait_clk(3);
		chk({31'h0000_0000, irq_match_a}, 32'h0000_0000);
		global_irq_en <= 1'b1;
		wait_clk(3);
		vector_ack <= 4'b0100;
		@(posedge clk);
		vector_ack <= 4'b0000;
		wait_clk(3);
		chk({31'h0000_0000, irq_match_a}, 32'h0000_0000);
		rd_chk(OFF_FLAGS, 8'h00);
		wr(OFF_CNT_H, 8'hFF);
		wr(OFF_CNT_L, 8'hFE);
		wr(OFF_CTRL_B, 8'h01);
		wait_clk(6);
		wr(OFF_CTRL_B, 8'h00);
		apb(1'b0, OFF_FLAGS, 8'h00);
		chk(rdat & 32'h0000_0080, 32'h0000_0080);
		chk({31'h0000_0000, irq_overflow}, 32'h0000_0001);
		wr(OFF_FLAGS, 8'hFF);
		rd_chk(OFF_FLAGS, 8'h00);
		$display("test compare and interrupts done");

		wr(OFF_CTRL_A, 8'h40);
		wr(OFF_FORCE, 8'h80);
		chk({31'h0000_0000, wave_out_a}, 32'h0000_0001);
		wr(OFF_FORCE, 8'h80);
		chk({31'h0000_0000, wave_out_a}, 32'h0000_0000);
		wr(OFF_CTRL_A, 8'hC1);
		wr(OFF_FORCE, 8'h00);
		chk({31'h0000_0000, wave_out_a}, 32'h0000_0000);
		// The one strobe written in a PWM mode, on purpose, to show it is ignored
		wr(OFF_FORCE, 8'h80);
		chk({31'h0000_0000, wave_out_a}, 32'h0000_0000);
		wr(OFF_CTRL_A, 8'hD0);
		wr(OFF_FORCE, 8'hC0);
		chk({30'h0000_0000, wave_out_a, wave_out_b}, 32'h0000_0003);
		rd_chk(OFF_FLAGS, 8'h00);
		chk({30'h0000_0000, irq_match_a, irq_match_b}, 32'h0000_0000);
		$display("test force compare done");

		wr(OFF_CNT_H, 8'h01);
		wr(OFF_CNT_L, 8'h23);
		cap_try(8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
		cap_try(8'h40, 1'b0, 1'b0, 1'b0, 1'b0);
		cap_try(8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
		cap_try(8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
		cap_try(8'h58, 1'b1, 1'b0, 1'b0, 1'b0);
		cap_try(8'h40, 1'b0, 1'b0, 1'b0, 1'b0);
		cap_try(8'h40, 1'b0, 1'b1, 1'b1, 1'b1);
		cap_try(8'h40, 1'b0, 1'b0, 1'b1, 1'b0);
		cap_try(8'h40, 1'b0, 1'b0, 1'b0, 1'b0);
		rd_chk(OFF_ICR_L, 8'h23);
		rd_chk(OFF_ICR_H, 8'h01);
		// A three-cycle glitch is shorter than the four agreeing samples the filter needs
		wr(OFF_CTRL_B, 8'hC0);
		capture_input_pin <= 1'b1;
		wait_clk(3);
		capture_input_pin <= 1'b0;
		wait_clk(16);
		rd_chk(OFF_FLAGS, 8'h00);
		cap_try(8'hC0, 1'b1, 1'b0, 1'b0, 1'b1);
		$display("test capture done");
		test_done();
	end
endmodule
